// ==== include/nor_boot_pkg.sv ====
package nor_boot_pkg;
	// pin and bus widths
	localparam int DATA_W      = 16;         // widest flash data bus
	localparam int ADDR_W      = 26;         // flash address, index 25 at most
	localparam int RATE_W      = 6;          // clock rate setting, nominal MHz
	localparam int HALF_W      = 8;          // half-period counter width
	// timing
	localparam int SYS_CLK_MHZ = 125;        // system clock rate
	localparam logic [RATE_W-1:0] DEFAULT_RATE = 6'h02; // 2 MHz nominal
	localparam int LATENCY_CYCLES = 4;       // config clock cycles at address 0
	localparam int RELEASE_CYCLES = 1;       // config clocks after complete
	// mode select value for parallel flash boot
	localparam logic [1:0] MODE_PARALLEL_NOR_BOOT = 2'h0;
	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RESET = 26'h0000000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

	// sequencer states
	typedef enum logic [2:0] {
		ST_WAIT    = 3'b000, // held by program or init
		ST_LATENCY = 3'b001, // address zero held
		ST_READ    = 3'b010, // sequential fetch
		ST_RELEASE = 3'b011, // wait for tristate release cycle
		ST_USER    = 3'b100, // pins handed to user logic
		ST_HALT    = 3'b101  // wrong mode strapped
	} boot_state_t;
endpackage

// ==== logic/parallel_nor_master_config_reader.sv ====
`timescale 1ns/1ns
// Behaviour
// - capture flash data on config clock rise
// - change address on config clock fall
// - stop fetching once complete pin high
// - release pins one clock after complete
// - data 8 or 16 bits, 26-bit address
// - hold address zero during start latency
// - start automatically, select low, issue addresses
// - default rate 2 gives 2 MHz clock; here 125/64, about 1.95 MHz
// - device sources config clock, nobody else
// - complete pin open-drain, optional active drive
// - clock frequency follows programmed rate setting
// - bit-swap each byte like slave parallel
// - select, output enable low then tristated
// - write enable high then tristated
// - init pin open-drain low on CRC error
// - high and low markers while configuring
module parallel_nor_master_config_reader
	import nor_boot_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              program_n,                 // full-chip reset, low holds
	input  wire logic              init_i,                    // init pin level
	input  wire logic [1:0]        mode_sel,                  // mode pins
	input  wire logic              pullup_swap_enable,        // 1 = no pull-ups while loading
	input  wire logic [RATE_W-1:0] clock_rate_setting,        // nominal MHz, 0 means default
	input  wire logic              complete_active_drive_option,
	input  wire logic              bus_wide,                  // 1 = 16-bit data bus
	input  wire logic [DATA_W-1:0] flash_data,                // flash read data
	input  wire logic              load_complete,             // engine finished loading
	input  wire logic              crc_error,                 // engine saw a CRC error
	input  wire logic              done_i,                    // complete pin level
	output logic                   config_clock,
	output logic                   config_clock_oe_n,
	output logic                   flash_select_n,
	output logic                   flash_select_oe_n,
	output logic                   flash_output_enable_n,
	output logic                   flash_output_enable_oe_n,
	output logic                   flash_write_enable_n,
	output logic                   flash_write_enable_oe_n,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic                   flash_addr_oe_n,
	output logic                   high_while_configuring,
	output logic                   low_while_configuring,
	output logic                   marker_oe_n,
	output logic                   init_o,
	output logic                   init_oe_n,
	output logic                   done_o,
	output logic                   done_oe_n,
	output logic                   io_pullup_enable,
	output logic [DATA_W-1:0]      cfg_data,                  // bit-swapped word
	output logic                   cfg_data_wide,             // 1 = all 16 bits valid
	output logic                   cfg_data_valid             // one-cycle pulse
);

	// half period in system clocks, rounded up so the clock is never faster
	function automatic logic [HALF_W-1:0] half_period(input logic [RATE_W-1:0] rate);
		logic [RATE_W-1:0] r;
		int                n;
		r = (rate == '0) ? DEFAULT_RATE : rate;
		n = (SYS_CLK_MHZ + 2 * int'(r) - 1) / (2 * int'(r));
		half_period = HALF_W'(n);
	endfunction

	// reverse bit order inside one byte
	function automatic logic [7:0] swap_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			swap_byte[i] = b[7-i];
		end
	endfunction

	boot_state_t       state_q;        // sequencer state
	logic [HALF_W-1:0] half_cnt_q;     // divider counter
	logic [HALF_W-1:0] half_len_q;     // latched half period
	// the config_clock port flop doubles as the divider level, so the pin
	// edges are the very edges that move the address and capture data
	logic              rise_en;        // config clock rises this cycle in latency, read or release; also high while parked in ST_USER or ST_HALT
	logic              fall_en;        // config clock falls this cycle
	logic [3:0]        wait_cnt_q;     // latency and release counter
	logic              done_seen_q;    // complete pin registered
	logic              complete_q;     // engine finished, sticky
	logic              crc_q;          // CRC error, sticky
	logic              sampled_q;      // mode pins taken
	logic              active;         // flash pins driven

	assign rise_en = (half_cnt_q == '0) && !config_clock && (state_q != ST_WAIT);
	assign fall_en = (half_cnt_q == '0) && config_clock;
	assign active  = (state_q == ST_LATENCY) || (state_q == ST_READ) ||
	                 (state_q == ST_RELEASE);

	// divider; rate is relatched each low phase so a new setting takes
	// effect without a runt pulse
	always_ff @(posedge clk) begin
		if (!rst_b || !program_n) begin
			half_cnt_q   <= '0;
			half_len_q   <= half_period(DEFAULT_RATE);
			config_clock <= 1'b0;
		end else if (state_q == ST_WAIT || state_q == ST_USER || state_q == ST_HALT) begin
			// parked low outside a load; the rise that ends ST_RELEASE still shows on the pin as a one-cycle high pulse
			half_cnt_q   <= '0;
			config_clock <= 1'b0;
			half_len_q   <= half_period(clock_rate_setting);
		end else if (half_cnt_q == '0) begin
			config_clock <= !config_clock;
			half_cnt_q   <= half_len_q - 1'b1;
			if (config_clock) begin
				half_len_q <= half_period(clock_rate_setting);
			end
		end else begin
			half_cnt_q <= half_cnt_q - 1'b1;
		end
	end

	// clock pin driven only while loading; nothing else may drive it
	// enable follows the state one cycle late, as every flash control does
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			config_clock_oe_n <= 1'b1;
		end else begin
			config_clock_oe_n <= !active;
		end
	end

	// complete pin registered before use
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			done_seen_q <= 1'b0;
		end else begin
			done_seen_q <= done_i;
		end
	end

	// sequencer
	always_ff @(posedge clk) begin
		if (!rst_b || !program_n) begin
			state_q    <= ST_WAIT;
			wait_cnt_q <= '0;
			sampled_q  <= 1'b0;
		end else begin
			case (state_q)
				ST_WAIT: begin
					// init held low by the board postpones the start
					if (init_i) begin
						sampled_q  <= 1'b1;
						wait_cnt_q <= '0;
						if (mode_sel == MODE_PARALLEL_NOR_BOOT) begin
							state_q <= ST_LATENCY;
						end else begin
							state_q <= ST_HALT;
						end
					end
				end
				ST_LATENCY: begin
					// address zero stays put through the latency
					if (fall_en) begin
						if (wait_cnt_q == 4'(LATENCY_CYCLES - 1)) begin
							state_q <= ST_READ;
						end else begin
							wait_cnt_q <= wait_cnt_q + 1'b1;
						end
					end
				end
				ST_READ: begin
					if (done_seen_q) begin
						state_q    <= ST_RELEASE;
						wait_cnt_q <= '0;
					end
				end
				ST_RELEASE: begin
					// release on the RELEASE_CYCLES-th config clock rise past complete
					if (rise_en) begin
						if (wait_cnt_q == 4'(RELEASE_CYCLES - 1)) begin
							state_q <= ST_USER;
						end else begin
							wait_cnt_q <= wait_cnt_q + 1'b1;
						end
					end
				end
				ST_USER: state_q <= ST_USER;
				ST_HALT: state_q <= ST_HALT;
				default: state_q <= ST_WAIT;
			endcase
		end
	end

	// address: steps only on falling edges, half a period before capture; reset and ST_WAIT return it to zero
	always_ff @(posedge clk) begin
		if (!rst_b || !program_n) begin
			flash_addr <= ADDR_RESET;
		end else if (state_q == ST_WAIT) begin
			flash_addr <= ADDR_RESET;
		end else if (state_q == ST_READ && fall_en && !done_seen_q) begin
			flash_addr <= flash_addr + 1'b1;
		end
	end

	// data capture on rising edges; narrow bus uses the low byte only
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfg_data       <= DATA_RESET;
			cfg_data_wide  <= 1'b0;
			cfg_data_valid <= 1'b0;
		end else begin
			cfg_data_valid <= 1'b0;
			if (state_q == ST_READ && rise_en && !done_seen_q) begin
				cfg_data_valid <= 1'b1;
				cfg_data_wide  <= bus_wide;
				cfg_data[7:0]  <= swap_byte(flash_data[7:0]);
				cfg_data[15:8] <= bus_wide ? swap_byte(flash_data[15:8]) : 8'h00;
			end
		end
	end

	// flash controls: driven while loading, tristated afterwards
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			flash_select_n           <= 1'b1;
			flash_select_oe_n        <= 1'b1;
			flash_output_enable_n    <= 1'b1;
			flash_output_enable_oe_n <= 1'b1;
			flash_write_enable_n     <= 1'b1;
			flash_write_enable_oe_n  <= 1'b1;
			flash_addr_oe_n          <= 1'b1;
		end else begin
			flash_select_n           <= !active;
			flash_select_oe_n        <= !active;
			flash_output_enable_n    <= !active;
			flash_output_enable_oe_n <= !active;
			flash_write_enable_n     <= 1'b1;
			flash_write_enable_oe_n  <= !active;
			flash_addr_oe_n          <= !active;
		end
	end

	// width markers for the flash byte/word control
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			high_while_configuring <= 1'b1;
			low_while_configuring  <= 1'b0;
			marker_oe_n            <= 1'b1;
		end else begin
			high_while_configuring <= 1'b1;
			low_while_configuring  <= 1'b0;
			marker_oe_n            <= !active;
		end
	end

	// weak pull-ups on user pins while loading unless swapped off
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			io_pullup_enable <= 1'b0;
		end else begin
			io_pullup_enable <= (state_q != ST_USER) && !pullup_swap_enable;
		end
	end

	// sticky engine status; set wins since nothing clears but reset
	always_ff @(posedge clk) begin
		if (!rst_b || !program_n) begin
			complete_q <= 1'b0;
			crc_q      <= 1'b0;
		end else begin
			complete_q <= complete_q || (load_complete && active);
			crc_q      <= crc_q || (crc_error && sampled_q);
		end
	end

	// init pin: input until mode sampled, then open-drain error flag
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			init_o    <= 1'b0;
			init_oe_n <= 1'b1;
		end else begin
			init_o    <= 1'b0;
			init_oe_n <= !(sampled_q && crc_q);
		end
	end

	// complete pin: pulled low until finished, then released or driven
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			done_o    <= 1'b0;
			done_oe_n <= 1'b0;
		end else if (!complete_q) begin
			done_o    <= 1'b0;
			done_oe_n <= 1'b0;
		end else begin
			done_o    <= complete_active_drive_option;
			done_oe_n <= !complete_active_drive_option;
		end
	end

endmodule // parallel_nor_master_config_reader

// ==== tb/nor_flash_model.sv ====
`timescale 1ns/1ns
// asynchronous nor flash, ready for reads from time zero
module nor_flash_model
	import nor_boot_pkg::*;
(
	input  wire logic              sel_n,   // chip select, low active
	input  wire logic              oe_n,    // output enable, low active
	input  wire logic              we_n,    // write enable, held high: read-only board
	input  wire logic [ADDR_W-1:0] addr,    // read address
	output logic      [DATA_W-1:0] data     // read data
);
	logic [DATA_W-1:0] word;                // stored word at addr
	// content derived from the low address byte, so words repeat every 256 addresses
	assign word = {addr[7:0] ^ 8'ha5, addr[7:0]};
	// released bus shows the inverse, never a stale copy
	assign data = (!sel_n && !oe_n && we_n) ? word : ~word;
endmodule // nor_flash_model

// ==== tb/nor_reader_properties.sv ====
`timescale 1ns/1ns
// pin-level checks of the flash reader
module nor_reader_props
	import nor_boot_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic              done_i,
	input wire logic              complete_active_drive_option,
	input wire logic              config_clock,
	input wire logic              flash_select_n,
	input wire logic              flash_select_oe_n,
	input wire logic              flash_output_enable_n,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic              high_while_configuring,
	input wire logic              low_while_configuring,
	input wire logic              marker_oe_n,
	input wire logic              init_o,
	input wire logic              init_oe_n,
	input wire logic              done_oe_n,
	input wire logic [DATA_W-1:0] cfg_data,
	input wire logic              cfg_data_wide,
	input wire logic              cfg_data_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// nonzero address moves land on the clock fall itself
	a_addr_on_fall: assert property (
		$changed(flash_addr) && flash_addr != 26'h0 |-> $fell(config_clock))
		else $error("address changed away from a clock fall");
	a_addr_step_one: assert property (
		$changed(flash_addr) && flash_addr != 26'h0 |-> flash_addr == $past(flash_addr) + 26'h1)
		else $error("address did not step by one");
	a_zero_hold: assert property (
		$fell(flash_select_oe_n) |-> (flash_addr == 26'h0) [*8])
		else $error("start address zero not held");
	a_valid_in_high: assert property (cfg_data_valid |-> $rose(config_clock))
		else $error("word not captured on a clock rise");
	a_narrow_upper: assert property (
		cfg_data_valid && !cfg_data_wide |-> cfg_data[15:8] == 8'h00)
		else $error("narrow word has upper byte set");
	a_stop_on_done: assert property (
		done_i [*4] |-> !cfg_data_valid && $stable(flash_addr))
		else $error("fetch continued after complete");
	a_release_bound: assert property ($rose(done_i) |-> ##[1:300] flash_select_oe_n)
		else $error("pins not released after complete");
	a_select_low: assert property (
		!flash_select_oe_n |-> !flash_select_n && !flash_output_enable_n)
		else $error("select or output enable driven high");
	a_marker_level: assert property (
		!marker_oe_n |-> high_while_configuring && !low_while_configuring)
		else $error("marker levels wrong");
	a_done_open_drain: assert property (done_oe_n |-> !complete_active_drive_option)
		else $error("complete pin released with active drive chosen");
	a_init_drives_low: assert property (!init_oe_n |-> !init_o)
		else $error("init pin driven high");
	c_narrow_word: cover property (cfg_data_valid && !cfg_data_wide);
	c_complete: cover property ($rose(done_i));
	c_crc_flag: cover property ($fell(init_oe_n));
endmodule // nor_reader_props

bind parallel_nor_master_config_reader nor_reader_props u_props (.clk, .rst_b, .done_i,
	.complete_active_drive_option, .config_clock, .flash_select_n, .flash_select_oe_n,
	.flash_output_enable_n, .flash_addr, .high_while_configuring, .low_while_configuring,
	.marker_oe_n, .init_o, .init_oe_n, .done_oe_n, .cfg_data, .cfg_data_wide, .cfg_data_valid);

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
	import nor_boot_pkg::*;
	logic clk = 0, rst_b = 0, program_n = 1, init_i = 0, pullup_swap_enable = 0;
	logic complete_active_drive_option = 0, bus_wide = 1, load_complete = 0;
	logic crc_error = 0, done_i = 0;
	logic [1:0] mode_sel = 2'h0;                          // parallel boot strap
	// suspend pin strapped to ground; the block has no such input
	logic [RATE_W-1:0] clock_rate_setting = 6'h02;
	logic [DATA_W-1:0] flash_data, cfg_data;
	logic [ADDR_W-1:0] flash_addr;
	logic config_clock, config_clock_oe_n, flash_select_n, flash_select_oe_n;
	logic flash_output_enable_n, flash_output_enable_oe_n, flash_write_enable_n;
	logic flash_write_enable_oe_n, flash_addr_oe_n, high_while_configuring;
	logic low_while_configuring, marker_oe_n, init_o, init_oe_n, done_o, done_oe_n;
	logic io_pullup_enable, cfg_data_wide, cfg_data_valid;
	int num_errors = 0, cmp_count = 0;
	logic sel_pin, oe_pin, we_pin;  // flash controls as the flash sees them
	parallel_nor_master_config_reader uut (
		.clk, .rst_b, .program_n, .init_i, .mode_sel, .pullup_swap_enable, .clock_rate_setting,
		.complete_active_drive_option, .bus_wide, .flash_data, .load_complete, .crc_error,
		.done_i, .config_clock, .config_clock_oe_n, .flash_select_n, .flash_select_oe_n,
		.flash_output_enable_n, .flash_output_enable_oe_n, .flash_write_enable_n,
		.flash_write_enable_oe_n, .flash_addr, .flash_addr_oe_n, .high_while_configuring,
		.low_while_configuring, .marker_oe_n, .init_o, .init_oe_n, .done_o, .done_oe_n,
		.io_pullup_enable, .cfg_data, .cfg_data_wide, .cfg_data_valid);
	// weak board pull-ups hold released controls high, not at the last driven level
	assign sel_pin = flash_select_oe_n ? 1'b1 : flash_select_n;
	assign oe_pin  = flash_output_enable_oe_n ? 1'b1 : flash_output_enable_n;
	assign we_pin  = flash_write_enable_oe_n ? 1'b1 : flash_write_enable_n;
	nor_flash_model flash (.sel_n(sel_pin), .oe_n(oe_pin), .we_n(we_pin),
		.addr(flash_addr), .data(flash_data));
	// 125 MHz system clock
	always #4 clk = ~clk;
	// inputs change 1 ns after the edge, away from sampling
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function automatic logic [7:0] rev(input logic [7:0] b);
		for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
	endfunction
	// one complete load: restart, measure clock, read words, finish
	task automatic run(input logic w, input logic [RATE_W-1:0] r, input logic o,
		input logic s, input int half);
		int n;
		int c;
		program_n = 0;
		done_i = 0;
		load_complete = 0;
		step(2);
		bus_wide = w;
		clock_rate_setting = r;
		complete_active_drive_option = o;
		pullup_swap_enable = s;
		program_n = 1;
		step(5);
		`CHECK(flash_select_n, 1'b0)
		`CHECK(flash_output_enable_n, 1'b0)
		`CHECK(flash_write_enable_n, 1'b1)
		`CHECK(flash_write_enable_oe_n, 1'b0)
		`CHECK(config_clock_oe_n, 1'b0)
		`CHECK(io_pullup_enable, ~s)
		// the first high phase is already running here; measure a fresh one
		n = 0;
		while (config_clock !== 1'b0 && n < 500) begin step(1); n++; end
		n = 0;
		while (config_clock !== 1'b1 && n < 500) begin step(1); n++; end
		`CHECK(config_clock, 1'b1)
		n = 0;
		while (config_clock === 1'b1 && n < 500) begin step(1); n++; end
		`CHECK(n, half)
		// word k comes from address k, each byte bit-reversed
		for (int k = 0; k < 6; k++) begin
			n = 0;
			while (cfg_data_valid !== 1'b1 && n < 500) begin step(1); n++; end
			`CHECK(cfg_data_valid, 1'b1)
			`CHECK(cfg_data, {rev(k[7:0] ^ 8'ha5) & {8{w}}, rev(k[7:0])})
			`CHECK(cfg_data_wide, w)
			step(1);
		end
		load_complete = 1;
		done_i = 1;
		step(3);
		c = 0;
		repeat (4 * half + 8) begin step(1); if (cfg_data_valid !== 1'b0) c++; end
		`CHECK(c, 0)
		`CHECK(flash_select_oe_n, 1'b1)
		`CHECK(flash_write_enable_oe_n, 1'b1)
		`CHECK(marker_oe_n, 1'b1)
		`CHECK(flash_addr_oe_n, 1'b1)
		`CHECK(io_pullup_enable, 1'b0)
		`CHECK(flash_output_enable_oe_n, 1'b1)
		`CHECK(config_clock_oe_n, 1'b1)
		`CHECK(done_oe_n, ~o)
		`CHECK(done_o, o)
	endtask
	// verdict in one place
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		step(20);
		rst_b = 1;
		step(10);
		`CHECK(flash_select_oe_n, 1'b1)
		init_i = 1;
		step(5);
		`CHECK(flash_select_n, 1'b0)
		run(1'b1, 6'h02, 1'b0, 1'b0, 32);
		run(1'b0, 6'h08, 1'b1, 1'b1, 8);
		run(1'b1, 6'h00, 1'b0, 1'b0, 32);
		crc_error = 1;
		step(3);
		`CHECK(init_oe_n, 1'b0)
		`CHECK(init_o, 1'b0)
		crc_error = 0;
		// complete pin drops with the restart, as the device pulls it low again
		done_i = 0;
		mode_sel = 2'h1;
		program_n = 0;
		step(2);
		program_n = 1;
		step(300);
		`CHECK(flash_select_oe_n, 1'b1)
		tally_and_finish;
	end
	// hang guard, well past the expected few thousand cycles
	initial begin
		#160000;
		num_errors++;
		tally_and_finish;
	end
endmodule // tb
